//--- src/wdt_top.sv
/*
 * Watchdog timer with APB register slave, interrupt and reset outputs.
 * Assumes sys_clk is the only clock of this instance and that the
 * system reset logic eventually pulls rst after wdt_rst_o rises.
 */
`timescale 1ns/1ps
module wdt_top
    import wdt_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              dbg_halt,
    output logic                   irq_o,
    output logic                   nmi_o,
    output logic                   wdt_rst_o
);

    // ****************************************************************
    // State
    // ****************************************************************
    logic [31:0]      load_q;
    logic [31:0]      load_d;
    logic [31:0]      cnt_q;
    logic [31:0]      cnt_d;
    wdt_ctrl_t        ctrl_q;
    wdt_ctrl_t        ctrl_d;
    wdt_ctrl_t        ctrl_wr;
    logic [EVT_W-1:0] ris_q;
    logic [EVT_W-1:0] ris_d;
    logic [EVT_W-1:0] ris_set;
    logic [EVT_W-1:0] ris_clr;
    logic [EVT_W-1:0] mask_q;
    logic [EVT_W-1:0] mask_d;
    logic [EVT_W-1:0] mis;
    logic             lock_q;
    logic             lock_d;
    logic             rst_out_q;
    logic             rst_out_d;
    logic [31:0]      prdata_q;
    logic [31:0]      prdata_d;
    logic             halt_s;
    logic             acc_wr;
    logic             setup_rd;
    logic             wr_ok;
    logic             mapped;
    logic             tick;
    logic             tmo;

    // The debug halt may come from another clock domain.
    wdt_sync u_halt_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .async_i (dbg_halt),
        .sync_o  (halt_s)
    );

    // ****************************************************************
    // APB decode
    // ****************************************************************
    // Zero wait states: read data is captured in the setup cycle.
    assign acc_wr   = psel & penable & pwrite;
    assign setup_rd = psel & ~penable & ~pwrite;
    assign wr_ok    = acc_wr & ~lock_q;
    assign ctrl_wr  = wdt_ctrl_t'(pwdata[CTRL_W-1:0]);

    always_comb begin
        case (paddr)
            OFS_LOAD,
            OFS_VALUE,
            OFS_CTRL,
            OFS_RIS,
            OFS_MIS,
            OFS_MASK,
            OFS_LOCK: mapped = 1'b1;
            default:  mapped = 1'b0;
        endcase
    end

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // ****************************************************************
    // Counter and configuration
    // ****************************************************************
    // The count pauses only when the stall option is set.
    assign tick = ctrl_q.run & ~(ctrl_q.stall_en & halt_s);
    assign tmo  = tick & (cnt_q == 32'h0);

    always_comb begin
        load_d    = load_q;
        cnt_d     = cnt_q;
        ctrl_d    = ctrl_q;
        mask_d    = mask_q;
        lock_d    = lock_q;
        rst_out_d = rst_out_q;
        ris_set   = '0;
        ris_clr   = '0;
        if (tmo) begin
            cnt_d            = load_q;
            ris_set[EVT_TMO] = 1'b1;
            if (ris_q[EVT_TMO]) begin
                ris_set[EVT_SECOND] = 1'b1;
                if (ctrl_q.rst_en) begin
                    rst_out_d = 1'b1;
                end
            end
        end else if (tick) begin
            cnt_d = cnt_q - 32'h1;
        end
        if (wr_ok && paddr == OFS_LOAD) begin
            load_d = pwdata;
            if (ctrl_q.run) begin
                cnt_d = pwdata;
            end
            if (pwdata == 32'h0) begin
                ris_set[EVT_TMO] = 1'b1;
            end
        end
        if (wr_ok && paddr == OFS_CTRL) begin
            // Once started, the watchdog can only be stopped by reset.
            ctrl_d.run      = ctrl_q.run | ctrl_wr.run;
            ctrl_d.rst_en   = ctrl_wr.rst_en;
            ctrl_d.int_nmi  = ctrl_wr.int_nmi;
            ctrl_d.stall_en = ctrl_wr.stall_en;
            if (ctrl_wr.run && !ctrl_q.run) begin
                cnt_d           = load_q;
                mask_d[EVT_TMO] = 1'b1;
            end
        end
        if (wr_ok && paddr == OFS_MASK) begin
            mask_d = pwdata[EVT_W-1:0];
        end
        if (acc_wr && paddr == OFS_RIS) begin
            ris_clr = pwdata[EVT_W-1:0];
        end
        if (acc_wr && paddr == OFS_LOCK) begin
            lock_d = (pwdata != UNLOCK_KEY);
        end
    end

    // A new event in the clear cycle survives the clear.
    assign ris_d = (ris_q & ~ris_clr) | ris_set;
    assign mis   = ris_q & mask_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            load_q    <= LOAD_RST;
            cnt_q     <= LOAD_RST;
            ctrl_q    <= CTRL_RST;
            ris_q     <= EVT_RST;
            mask_q    <= EVT_RST;
            lock_q    <= 1'b0;
            rst_out_q <= 1'b0;
        end else begin
            load_q    <= load_d;
            cnt_q     <= cnt_d;
            ctrl_q    <= ctrl_d;
            ris_q     <= ris_d;
            mask_q    <= mask_d;
            lock_q    <= lock_d;
            rst_out_q <= rst_out_d;
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    always_comb begin
        prdata_d = prdata_q;
        if (setup_rd) begin
            case (paddr)
                OFS_LOAD:  prdata_d = load_q;
                OFS_VALUE: prdata_d = cnt_q;
                OFS_CTRL:  prdata_d = {28'h0, ctrl_q};
                OFS_RIS:   prdata_d = {30'h0, ris_q};
                OFS_MIS:   prdata_d = {30'h0, mis};
                OFS_MASK:  prdata_d = {30'h0, mask_q};
                OFS_LOCK:  prdata_d = {31'h0, lock_q};
                default:   prdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata_q <= 32'h0;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // In NMI mode the timeout leaves the normal line; second-timeout
    // events still go there so that nothing is silently dropped.
    assign prdata    = prdata_q;
    assign irq_o     = ctrl_q.int_nmi ? mis[EVT_SECOND] : (|mis);
    assign nmi_o     = ctrl_q.int_nmi & mis[EVT_TMO];
    assign wdt_rst_o = rst_out_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    logic wr_load;
    logic wr_ctrl;
    assign wr_load = wr_ok && paddr == OFS_LOAD;
    assign wr_ctrl = wr_ok && paddr == OFS_CTRL;

    sequence s_timeout;
        tick && cnt_q == 32'h0;
    endsequence

    sequence s_uncleared_timeout;
        s_timeout ##0 ris_q[EVT_TMO];
    endsequence

    a_count_down: assert property (
        tick && cnt_q != 32'h0 && !wr_load && !wr_ctrl
        |=> cnt_q == $past(cnt_q) - 32'h1)
        else $error("counter did not decrement");

    a_first_timeout: assert property (
        s_timeout ##0 !(acc_wr && paddr == OFS_RIS)
        |=> ris_q[EVT_TMO])
        else $error("timeout did not raise status");

    a_enable_both: assert property (
        wr_ctrl && ctrl_wr.run && !ctrl_q.run
        |=> ctrl_q.run && mask_q[EVT_TMO] && cnt_q == $past(load_q))
        else $error("enable did not start counter and interrupt");

    a_timeout_reload: assert property (
        s_timeout ##0 !wr_load |=> cnt_q == $past(load_q))
        else $error("counter not reloaded after timeout");

    a_second_reset: assert property (
        s_uncleared_timeout ##0 ctrl_q.rst_en
        |=> wdt_rst_o [*3])
        else $error("second timeout did not hold reset");

    a_reset_gate: assert property (
        !ctrl_q.rst_en && !wr_ctrl && !wdt_rst_o |=> !wdt_rst_o)
        else $error("reset rose while reset disabled");

    a_load_running: assert property (
        wr_load && ctrl_q.run |=> cnt_q == $past(pwdata))
        else $error("running counter did not take new load");

    a_locked_hold: assert property (
        lock_q && acc_wr && paddr != OFS_LOCK
        |=> $stable(load_q) && $stable(mask_q) && $stable(ctrl_q))
        else $error("configuration changed while locked");

    a_clear_source: assert property (
        acc_wr && paddr == OFS_RIS && pwdata[EVT_TMO] && !tmo && !wr_load
        |=> !ris_q[EVT_TMO] ##0 !nmi_o)
        else $error("interrupt clear did not take effect");

    a_irq_level: assert property (
        !ctrl_q.int_nmi && ris_q[EVT_TMO] && mask_q[EVT_TMO] |-> irq_o)
        else $error("unmasked timeout not on interrupt line");

    a_nmi_route: assert property (
        ctrl_q.int_nmi |-> nmi_o == (ris_q[EVT_TMO] && mask_q[EVT_TMO]))
        else $error("nmi output disagrees with masked status");

    a_stall_hold: assert property (
        ctrl_q.stall_en && halt_s && !wr_load && !wr_ctrl
        |=> $stable(cnt_q))
        else $error("counter moved while stalled");

    a_zero_load: assert property (
        wr_load && pwdata == 32'h0 |=> ris_q[EVT_TMO])
        else $error("zero load did not raise interrupt");

    a_unlock_key: assert property (
        acc_wr && paddr == OFS_LOCK
        |=> lock_q == ($past(pwdata) != UNLOCK_KEY))
        else $error("lock state wrong after lock write");

    a_nmi_off_irq: assert property (
        ctrl_q.int_nmi && !ris_q[EVT_SECOND] |-> !irq_o)
        else $error("timeout reached standard line in nmi mode");

    a_reset_sticky: assert property (
        wdt_rst_o |=> wdt_rst_o)
        else $error("reset request dropped before reset");

    a_lock_readback: assert property (
        setup_rd && paddr == OFS_LOCK
        |=> prdata == {31'h0, $past(lock_q)})
        else $error("lock state read back wrong");

endmodule

//--- src/wdt_pkg.sv
/*
 * Constants, register map and carrier types of the watchdog timer.
 * Assumes a 32-bit APB with byte addresses in a 12-bit window and a
 * single clock for the whole block.
 */
package wdt_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int          ADDR_W      = 12;
    localparam logic [11:0] OFS_LOAD    = 12'h000;
    localparam logic [11:0] OFS_VALUE   = 12'h004;
    localparam logic [11:0] OFS_CTRL    = 12'h008;
    localparam logic [11:0] OFS_RIS     = 12'h00C;
    localparam logic [11:0] OFS_MIS     = 12'h010;
    localparam logic [11:0] OFS_MASK    = 12'h014;
    localparam logic [11:0] OFS_LOCK    = 12'h018;

    // ****************************************************************
    // Reset values and key
    // ****************************************************************
    localparam logic [31:0] LOAD_RST    = 32'hFFFFFFFF;
    // Arbitrary value; any other value written to the lock locks.
    localparam logic [31:0] UNLOCK_KEY  = 32'h5A5AC3C3;
    localparam int          EVT_W       = 2;
    localparam int          EVT_TMO     = 0;
    localparam int          EVT_SECOND  = 1;
    localparam logic [1:0]  EVT_RST     = 2'h0;
    localparam int          CTRL_W      = 4;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef struct packed {
        logic stall_en;
        logic int_nmi;
        logic rst_en;
        logic run;
    } wdt_ctrl_t;

    localparam wdt_ctrl_t CTRL_RST = '{default: 1'b0};

endpackage

//--- src/wdt_sync.sv
/*
 * Two-flop synchroniser for one level.
 * Assumes the input may change at any time relative to the clock.
 */
`timescale 1ns/1ps
module wdt_sync (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic async_i,
    output logic      sync_o
);
    logic meta_q;
    logic sync_q;

    // The first flop feeds only the second to let metastability settle.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule

//--- dv/wdt_host_model.sv
/*
 * Model of the interrupt controller and reset logic beside the watchdog.
 * Assumes the interrupt and reset requests are levels on sys_clk.
 */
`timescale 1ns/1ps
module wdt_host_model (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       irq_o,
    input  wire logic       nmi_o,
    input  wire logic       wdt_rst_o,
    output logic      [7:0] irq_cnt,
    output logic      [7:0] nmi_cnt,
    output logic            rst_seen
);
    logic irq_q;
    logic nmi_q;

    // ****************************************************************
    // Entry counting
    // ****************************************************************
    // Entries are counted on rising levels only, since a handler that
    // clears late would otherwise look like many entries.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_q    <= 1'b0;
            nmi_q    <= 1'b0;
            irq_cnt  <= 8'h00;
            nmi_cnt  <= 8'h00;
            rst_seen <= 1'b0;
        end else begin
            irq_q <= irq_o;
            nmi_q <= nmi_o;
            if (irq_o && !irq_q) irq_cnt <= irq_cnt + 8'h01;
            if (nmi_o && !nmi_q) nmi_cnt <= nmi_cnt + 8'h01;
            if (wdt_rst_o) rst_seen <= 1'b1;
        end
    end
endmodule

//--- dv/wdt_top_tb.sv
/*
 * Self-checking bench of the watchdog over APB, with a host model.
 * Assumes the zero-wait APB slave and register map of wdt_pkg.
 */
`timescale 1ns/1ps
module wdt_top_tb;
    import wdt_pkg::*;
    typedef struct {logic [11:0] a; logic [31:0] v; logic e;} wdt_row_t;
    logic        sys_clk, rst, psel, penable, pwrite, dbg_halt;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, irq_o, nmi_o, wdt_rst_o, err;
    logic [7:0]  irq_cnt, nmi_cnt;
    logic        rst_seen;
    int          error_cnt, n_checks, n;
    wdt_row_t    rows[8] = '{'{OFS_LOAD, LOAD_RST, 1'b0},
        '{OFS_VALUE, LOAD_RST, 1'b0}, '{OFS_CTRL, 32'h0, 1'b0},
        '{OFS_RIS, 32'h0, 1'b0}, '{OFS_MIS, 32'h0, 1'b0},
        '{OFS_MASK, 32'h0, 1'b0}, '{OFS_LOCK, 32'h0, 1'b0},
        '{12'h01C, 32'h0, 1'b1}};

    wdt_top u_wdt_top (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dbg_halt(dbg_halt), .irq_o(irq_o),
        .nmi_o(nmi_o), .wdt_rst_o(wdt_rst_o));
    wdt_host_model u_wdt_host_model (.sys_clk(sys_clk), .rst(rst),
        .irq_o(irq_o), .nmi_o(nmi_o), .wdt_rst_o(wdt_rst_o),
        .irq_cnt(irq_cnt), .nmi_cnt(nmi_cnt), .rst_seen(rst_seen));

    // ****************************************************************
    // Clock, tasks
    // ****************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic chk(input string s, input logic [31:0] e, g);
        n_checks++;
        if (e !== g) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask

    // Write data is a full word, so the unlock key reaches the slave whole.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic do_reset();
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
    endtask

    // Waits for irq (0), nmi (1) or reset request (2); n counts cycles.
    task automatic wait_out(input int s);
        n = 0;
        while (n < 60 && !((s == 0 && irq_o === 1'b1) ||
               (s == 1 && nmi_o === 1'b1) ||
               (s == 2 && wdt_rst_o === 1'b1))) begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #(40 * 5000);
        error_cnt++;
        print_verdict();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        rst       = 1'b1;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 12'h000;
        pwdata    = 32'h0;
        dbg_halt  = 1'b0;
        error_cnt = 0;
        n_checks  = 0;
        do_reset();
        foreach (rows[i]) begin
            apb(1'b0, rows[i].a, 32'h0);
            chk("reset read", rows[i].v, rd);
            chk("slave error", {31'h0, rows[i].e}, {31'h0, err});
        end
        $display("test reset_values done");
        // A period of 17 ticks leaves room to clear before the next zero.
        apb(1'b1, OFS_LOAD, 32'h10);
        apb(1'b1, OFS_CTRL, 32'h3);
        apb(1'b0, OFS_MASK, 32'h0);
        chk("mask by run", 32'h1, rd);
        wait_out(0);
        chk("first timeout", 32'h1, 32'(n > 0 && n <= 17));
        apb(1'b0, OFS_MIS, 32'h0);
        chk("masked status", 32'h1, rd);
        apb(1'b0, OFS_VALUE, 32'h0);
        chk("reloaded", 32'h1, 32'(rd <= 32'h10 && rd >= 32'h8));
        apb(1'b1, OFS_RIS, 32'h1);
        @(negedge sys_clk);
        chk("irq cleared", 32'h0, {31'h0, irq_o});
        wait_out(0);
        chk("cleared no reset", 32'h0, {31'h0, wdt_rst_o});
        wait_out(2);
        chk("second timeout", 32'h11, n);
        apb(1'b0, OFS_RIS, 32'h0);
        chk("both flags", 32'h3, rd);
        chk("host entries", 32'h2, {24'h0, irq_cnt});
        chk("host reset", 32'h1, {31'h0, rst_seen});
        $display("test two_timeouts done");
        do_reset();
        apb(1'b1, OFS_LOCK, 32'h0);
        apb(1'b0, OFS_LOCK, 32'h0);
        chk("locked", 32'h1, rd);
        apb(1'b1, OFS_LOAD, 32'h9);
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b0, OFS_LOAD, 32'h0);
        chk("load kept", LOAD_RST, rd);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl kept", 32'h0, rd);
        apb(1'b1, OFS_LOCK, UNLOCK_KEY);
        apb(1'b0, OFS_LOCK, 32'h0);
        chk("unlocked", 32'h0, rd);
        apb(1'b1, OFS_LOAD, 32'h0);
        apb(1'b0, OFS_RIS, 32'h0);
        chk("zero load", 32'h1, rd);
        $display("test lock done");
        do_reset();
        apb(1'b1, OFS_LOAD, 32'h3);
        apb(1'b1, OFS_CTRL, 32'h5);
        wait_out(1);
        chk("nmi fired", 32'h1, 32'(n < 12));
        chk("no plain irq", 32'h0, {31'h0, irq_o});
        apb(1'b1, OFS_RIS, 32'h3);
        @(negedge sys_clk);
        chk("nmi cleared", 32'h0, {31'h0, nmi_o});
        apb(1'b1, OFS_MASK, 32'h0);
        repeat (12) @(negedge sys_clk);
        chk("nmi masked", 32'h0, {31'h0, nmi_o});
        chk("nmi entries", 32'h2, {24'h0, nmi_cnt});
        chk("reset gated", 32'h0, {31'h0, rst_seen});
        $display("test nmi done");
        do_reset();
        dbg_halt <= 1'b1;
        apb(1'b1, OFS_LOAD, 32'h20);
        apb(1'b1, OFS_CTRL, 32'h9);
        repeat (4) @(posedge sys_clk);
        apb(1'b0, OFS_VALUE, 32'h0);
        chk("stall start", 32'h20, rd);
        repeat (4) @(posedge sys_clk);
        apb(1'b0, OFS_VALUE, 32'h0);
        chk("stalled", 32'h20, rd);
        dbg_halt <= 1'b0;
        apb(1'b1, OFS_LOAD, 32'h40);
        apb(1'b0, OFS_VALUE, 32'h0);
        chk("reload now", 32'h1, 32'(rd <= 32'h40 && rd >= 32'h3C));
        $display("test stall_reload done");
        print_verdict();
    end
endmodule
